// file: rtl/drs_regs.vh
/*
 reference select and validation block: register offsets, field
 positions, reset values and timing counts as macros.
 assumes a 32-bit avalon-mm slave with word-aligned byte addresses.
*/
`ifndef DRS_REGS_VH
`define DRS_REGS_VH

// byte offsets
`define DRS_OFS_CTRL 8'h00
`define DRS_OFS_PRIO 8'h04
`define DRS_OFS_MONEN 8'h08
`define DRS_OFS_VALT 8'h0C
`define DRS_OFS_SLEW 8'h10
`define DRS_OFS_FLOCK 8'h14
`define DRS_OFS_STAT 8'h18
`define DRS_OFS_MON 8'h1C
`define DRS_OFS_PPS 8'h20

// control field positions
`define DRS_CTRL_MODE_LSB 0
`define DRS_CTRL_MAN_LSB 2
`define DRS_CTRL_PINSEL 4
`define DRS_CTRL_CANCEL 5
`define DRS_CTRL_SLEW 6
`define DRS_CTRL_ZDS 7
`define DRS_CTRL_XOBYP 8
`define DRS_CTRL_HITLESS 9

// selection modes
`define DRS_MODE_AUTO_REV 2'h0
`define DRS_MODE_AUTO_NREV 2'h1
`define DRS_MODE_MAN_FALL 2'h2
`define DRS_MODE_MAN_HOLD 2'h3

// reset values
`define DRS_CTRL_RST 32'h0000_0000
`define DRS_PRIO_RST 32'h0000_3210
`define DRS_MONEN_RST 32'h0000_0000
`define DRS_VALT_RST 16'h0010
`define DRS_SLEW_RST 32'h0001_0004

// crystal range in khz
`define DRS_XO_MIN_KHZ 20'h0_2328
`define DRS_XO_MAX_KHZ 20'h2_7100

// monitor bits per input: freq, missing, runt, phase-valid
`define DRS_MON_FREQ 0
`define DRS_MON_MISS 1
`define DRS_MON_RUNT 2
`define DRS_MON_PHV 3

`endif

// file: rtl/drs_ref_select.v
/*
 reference selector and validation for one digital loop: monitor
 gating, validation timers, mode-driven selection, holdover/free-run,
 hitless switching controls, crystal monitor.
 assumes monitor flags and measurements arrive synchronous to clk and
 an avalon-mm master with waitrequest handling.
*/
`timescale 1ns/1ps
`include "drs_regs.vh"

// Contract
// R1 - auto revertive: choose the qualified input of highest priority
// R2 - auto revertive: switch at once to a newly qualified higher input
// R3 - auto non-revertive: keep present input until it is disqualified
// R4 - manual modes: choice from register field or selection pins
// R5 - manual fallback: on loss, move to best qualified input
// R6 - no qualified input: holdover if history valid, else free-run; holdover and free-run are kept when history_valid later changes
// R7 - manual holdover: on loss go to holdover or free-run directly
// R8 - manual modes: leave holdover when selected input requalifies
// R9 - hitless off: phase step passes through, loop bandwidth smooths
// R10 - cancellation: absorb offset on locked switch, hold unless slewing
// R11 - frequency-locked: equal frequency or integer-related dividers
// R12 - slew enabled: limit phase movement, remove build-out gradually
// R13 - slew limits also on holdover exit and unlocked switches
// R14 - 1-pps hitless only with zero-delay sync off and loop locked
// R15 - host waits for lock before 1-pps switch, soft reset otherwise
// R16 - gap no wider than a divided period; output averages input
// R17 - crystal loss clears only while frequency is inside range
// R18 - crystal bypass forces valid to control, flag unaffected
// R19 - 1-pps input: phase-valid monitor only, others disabled
// R20 - disabled monitor raises no flag and is ignored
// R21 - qualify only after enabled monitors clear for validation time
// R22 - flags to pins for any input, status bits for selected only
// R23 - four reference inputs, any signalling
// R24 - equal priority: lower-numbered input wins
module drs_ref_select
(
  // clock and reset
  input wire clk,
  input wire nrst,
  input wire clk_en,
  // avalon-mm slave
  input wire [7:0] avs_address,
  input wire avs_read,
  input wire avs_write,
  input wire [31:0] avs_writedata,
  input wire [3:0] avs_byteenable,
  output reg [31:0] avs_readdata,
  output wire avs_waitrequest,
  // monitor flags, 4 bits per input
  input wire [15:0] mon_flag_raw,
  // crystal measurement in khz
  input wire [19:0] xo_freq_khz,
  // selection pins and loop state
  input wire [1:0] sel_pins,
  input wire history_valid,
  input wire loop_locked,
  input wire [3:0] ref_is_pps,
  // selection outputs
  output reg [1:0] active_ref,
  output reg ref_valid_out,
  output reg holdover,
  output reg freerun,
  output reg switch_pulse,
  output reg absorb_offset,
  output reg slew_active,
  output reg phase_step_pass,
  // monitoring outputs
  output reg [15:0] status_pins,
  output reg [3:0] qualified,
  output reg crystal_loss_flag,
  output reg crystal_valid
);

  // selection state, one-hot
  localparam [2:0] ST_LOCKED = 3'b001;
  localparam [2:0] ST_HOLD = 3'b010;
  localparam [2:0] ST_FREE = 3'b100;

  // registers
  reg [31:0] ctrl_reg;
  reg [31:0] prio_reg;
  reg [31:0] monen_reg;
  reg [15:0] valt_reg;
  reg [31:0] slew_reg;
  reg [3:0] flock_reg;
  reg [2:0] state_reg;
  reg [2:0] state_next;
  reg [1:0] sel_next;
  reg [15:0] vcnt_reg [0:3];
  reg [15:0] slew_cnt_reg;
  reg [15:0] buildout_reg;
  reg rd_pend_reg;
  reg pps_ok;
  reg [1:0] best;
  reg best_ok;
  reg [15:0] mon_eff;
  reg [3:0] bad;
  integer i, j, k;

  wire [1:0] mode = ctrl_reg[`DRS_CTRL_MODE_LSB+1:`DRS_CTRL_MODE_LSB];
  wire manual = mode[1];
  wire [1:0] manual_reference_choice = ctrl_reg[`DRS_CTRL_PINSEL] ?
    sel_pins : ctrl_reg[`DRS_CTRL_MAN_LSB+1:`DRS_CTRL_MAN_LSB]; // [R4]
  wire phase_slew_enable = ctrl_reg[`DRS_CTRL_SLEW];
  wire zero_delay_sync = ctrl_reg[`DRS_CTRL_ZDS];
  wire crystal_monitor_bypass = ctrl_reg[`DRS_CTRL_XOBYP];
  wire [15:0] phase_slew_step_limit = slew_reg[15:0];
  wire [15:0] phase_slew_step_timer = slew_reg[31:16];
  wire xo_in_range = (xo_freq_khz >= `DRS_XO_MIN_KHZ) &&
    (xo_freq_khz <= `DRS_XO_MAX_KHZ);

  // priority field of input n (4 bits, lower value is higher priority)
  function [3:0] prio_of;
    input [31:0] p;
    input [1:0] n;
    begin
      prio_of = p[n*4 +: 4];
    end
  endfunction

  // bus answers reads one cycle later, writes at once
  assign avs_waitrequest = avs_read & ~rd_pend_reg;

  // monitor gating: disabled monitors and non-pps monitors on pps inputs
  always @*
  begin
    for (j = 0; j < 4; j = j + 1) // [R23]
    begin
      mon_eff[j*4 +: 4] = mon_flag_raw[j*4 +: 4] & monen_reg[j*4 +: 4];
      if (ref_is_pps[j])
        mon_eff[j*4 +: 3] = 3'b000; // [R19] [R20]
      else
        mon_eff[j*4+`DRS_MON_PHV] = 1'b0; // [R19]
      bad[j] = |mon_eff[j*4 +: 4];
    end
  end

  // best qualified input; ties go to the lower index
  always @*
  begin
    best = 2'd0;
    best_ok = 1'b0;
    for (k = 0; k < 4; k = k + 1)
      if (qualified[k] && (!best_ok ||
          prio_of(prio_reg, k[1:0]) < prio_of(prio_reg, best)))
      begin
        best = k[1:0]; // [R1] [R24]
        best_ok = 1'b1;
      end
  end

  // next selection and state
  always @*
  begin
    state_next = state_reg;
    sel_next = active_ref;
    pps_ok = 1'b1;
    case (state_reg)
      ST_LOCKED:
      begin
        if (mode == `DRS_MODE_AUTO_REV)
        begin
          if (best_ok)
            sel_next = best; // [R1] [R2]
        end
        else if (mode == `DRS_MODE_AUTO_NREV)
        begin
          if (!qualified[active_ref] && best_ok)
            sel_next = best; // [R3]
        end
        else if (qualified[manual_reference_choice])
          sel_next = manual_reference_choice; // [R4]
        else if (mode == `DRS_MODE_MAN_FALL && best_ok)
          sel_next = best; // [R5]
        if (!qualified[sel_next])
          state_next = history_valid ? ST_HOLD : ST_FREE; // [R6] [R7]
      end
      ST_HOLD, ST_FREE:
      begin
        if (manual)
        begin
          sel_next = manual_reference_choice;
          if (qualified[manual_reference_choice])
            state_next = ST_LOCKED; // [R8]
          else if (mode == `DRS_MODE_MAN_FALL && best_ok)
          begin
            sel_next = best; // [R5]
            state_next = ST_LOCKED;
          end
        end
        else if (best_ok)
        begin
          sel_next = best;
          state_next = ST_LOCKED;
        end
        if (state_next == state_reg && state_reg == ST_FREE &&
            history_valid)
          state_next = state_reg;
      end
      default:
        state_next = ST_FREE;
    endcase
    // 1-pps switch only with zero-delay sync off and loop locked
    if (ref_is_pps[active_ref] && ref_is_pps[sel_next] &&
        sel_next != active_ref && state_reg == ST_LOCKED &&
        (zero_delay_sync || !loop_locked))
      pps_ok = 1'b0; // [R14]
    if (!pps_ok && qualified[active_ref])
      sel_next = active_ref; // [R14]
  end

  // main sequential logic
  always @(posedge clk)
  begin
    if (!nrst)
    begin
      ctrl_reg <= `DRS_CTRL_RST;
      prio_reg <= `DRS_PRIO_RST;
      monen_reg <= `DRS_MONEN_RST;
      valt_reg <= `DRS_VALT_RST;
      slew_reg <= `DRS_SLEW_RST;
      flock_reg <= 4'h0;
      state_reg <= ST_FREE;
      active_ref <= 2'd0;
      holdover <= 1'b0;
      freerun <= 1'b1;
      ref_valid_out <= 1'b0;
      switch_pulse <= 1'b0;
      absorb_offset <= 1'b0;
      slew_active <= 1'b0;
      phase_step_pass <= 1'b0;
      slew_cnt_reg <= 16'h0000;
      buildout_reg <= 16'h0000;
      status_pins <= 16'h0000;
      qualified <= 4'h0;
      crystal_loss_flag <= 1'b1;
      crystal_valid <= 1'b0;
      avs_readdata <= 32'h0000_0000;
      rd_pend_reg <= 1'b0;
      for (i = 0; i < 4; i = i + 1)
        vcnt_reg[i] <= 16'h0000;
    end
    else if (clk_en)
    begin
      // register writes, byte lanes 0 and 1 honoured, all four lanes for slew, lane 0 only for flock
      if (avs_write)
      begin
        case (avs_address)
          `DRS_OFS_CTRL:
          begin
            if (avs_byteenable[0])
              ctrl_reg[7:0] <= avs_writedata[7:0];
            if (avs_byteenable[1])
              ctrl_reg[15:8] <= avs_writedata[15:8];
          end
          `DRS_OFS_PRIO:
          begin
            if (avs_byteenable[0])
              prio_reg[7:0] <= avs_writedata[7:0];
            if (avs_byteenable[1])
              prio_reg[15:8] <= avs_writedata[15:8];
          end
          `DRS_OFS_MONEN:
          begin
            if (avs_byteenable[0])
              monen_reg[7:0] <= avs_writedata[7:0];
            if (avs_byteenable[1])
              monen_reg[15:8] <= avs_writedata[15:8];
          end
          `DRS_OFS_VALT:
          begin
            if (avs_byteenable[0])
              valt_reg[7:0] <= avs_writedata[7:0];
            if (avs_byteenable[1])
              valt_reg[15:8] <= avs_writedata[15:8];
          end
          `DRS_OFS_SLEW:
          begin
            if (avs_byteenable[0])
              slew_reg[7:0] <= avs_writedata[7:0];
            if (avs_byteenable[1])
              slew_reg[15:8] <= avs_writedata[15:8];
            if (avs_byteenable[2])
              slew_reg[23:16] <= avs_writedata[23:16];
            if (avs_byteenable[3])
              slew_reg[31:24] <= avs_writedata[31:24];
          end
          `DRS_OFS_FLOCK:
            if (avs_byteenable[0])
              flock_reg <= avs_writedata[3:0]; // [R11]
          default:
            ;
        endcase
      end
      // reads, one wait state
      rd_pend_reg <= avs_read & ~rd_pend_reg;
      if (avs_read && !rd_pend_reg)
      begin
        case (avs_address)
          `DRS_OFS_CTRL: avs_readdata <= {22'h0, ctrl_reg[9:0]};
          `DRS_OFS_PRIO: avs_readdata <= {16'h0, prio_reg[15:0]};
          `DRS_OFS_MONEN: avs_readdata <= {16'h0, monen_reg[15:0]};
          `DRS_OFS_VALT: avs_readdata <= {16'h0, valt_reg};
          `DRS_OFS_SLEW: avs_readdata <= slew_reg;
          `DRS_OFS_FLOCK: avs_readdata <= {28'h0, flock_reg};
          `DRS_OFS_STAT:
            avs_readdata <= {16'h0, buildout_reg[7:0], crystal_loss_flag,
              slew_active, freerun, holdover, qualified};
          `DRS_OFS_MON:
            avs_readdata <= {26'h0, active_ref,
              mon_eff[active_ref*4 +: 4]}; // [R22]
          `DRS_OFS_PPS: avs_readdata <= {30'h0, loop_locked, pps_ok};
          default: avs_readdata <= 32'h0000_0000;
        endcase
      end
      // crystal monitor
      if (xo_in_range)
        crystal_loss_flag <= 1'b0; // [R17]
      else
        crystal_loss_flag <= 1'b1;
      crystal_valid <= xo_in_range | crystal_monitor_bypass; // [R18]
      // validation timers per input
      status_pins <= mon_eff; // [R22]
      for (i = 0; i < 4; i = i + 1)
      begin
        if (bad[i])
        begin
          vcnt_reg[i] <= 16'h0000;
          qualified[i] <= 1'b0;
        end
        else if (vcnt_reg[i] >= valt_reg)
          qualified[i] <= 1'b1; // [R21]
        else
          vcnt_reg[i] <= vcnt_reg[i] + 16'h0001;
      end
      // selection state
      state_reg <= state_next;
      active_ref <= sel_next;
      holdover <= state_next == ST_HOLD;
      freerun <= state_next == ST_FREE;
      ref_valid_out <= state_next == ST_LOCKED &&
        (xo_in_range | crystal_monitor_bypass); // [R18]
      switch_pulse <= (sel_next != active_ref) ||
        (state_next == ST_LOCKED && state_reg != ST_LOCKED);
      // hitless switching
      phase_step_pass <= 1'b0;
      if (state_reg == ST_LOCKED && state_next == ST_LOCKED &&
          sel_next != active_ref)
      begin
        if (!ctrl_reg[`DRS_CTRL_HITLESS])
          phase_step_pass <= 1'b1; // [R9] [R16]
        else if (ctrl_reg[`DRS_CTRL_CANCEL] &&
                 flock_reg[sel_next] && flock_reg[active_ref])
        begin
          absorb_offset <= 1'b1; // [R10] [R11]
          buildout_reg <= 16'hFFFF;
        end
        else if (phase_slew_enable)
          slew_active <= 1'b1; // [R13]
      end
      else if (state_reg != ST_LOCKED && state_next == ST_LOCKED &&
               phase_slew_enable)
        slew_active <= 1'b1; // [R13]
      // gradual removal of build-out at the programmed rate
      if (phase_slew_enable && (absorb_offset || slew_active))
      begin
        if (slew_cnt_reg >= phase_slew_step_timer)
        begin
          slew_cnt_reg <= 16'h0000;
          if (buildout_reg > phase_slew_step_limit)
            buildout_reg <= buildout_reg - phase_slew_step_limit; // [R12]
          else
          begin
            buildout_reg <= 16'h0000;
            absorb_offset <= 1'b0;
            slew_active <= 1'b0;
          end
        end
        else
          slew_cnt_reg <= slew_cnt_reg + 16'h0001;
      end
    end
  end

endmodule // drs_ref_select

// file: sim/drs_ref_select_chk.sv
/*
 port-level timing checks for the reference selector.
 assumes a bind onto drs_ref_select and one clock domain.
*/
`timescale 1ns/1ps
`include "drs_regs.vh"
module drs_ref_select_chk
(
  // clock and reset
  input wire clk,
  input wire nrst,
  input wire clk_en,
  // watched inputs
  input wire [15:0] mon_flag_raw,
  input wire [19:0] xo_freq_khz,
  input wire history_valid,
  // watched outputs
  input wire ref_valid_out,
  input wire holdover,
  input wire freerun,
  input wire [15:0] status_pins,
  input wire [3:0] qualified,
  input wire crystal_loss_flag,
  input wire crystal_valid
);
  wire [3:0] any_flag;
  wire xo_in;
  // per-input or of gated flags and the crystal range test
  assign any_flag = {|status_pins[15:12], |status_pins[11:8],
    |status_pins[7:4], |status_pins[3:0]};
  assign xo_in = (xo_freq_khz >= `DRS_XO_MIN_KHZ) &&
    (xo_freq_khz <= `DRS_XO_MAX_KHZ);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!nrst);
  // flag relations
  a_pins_gated: assert property ($past(clk_en) |->
    (status_pins & ~$past(mon_flag_raw)) == 16'h0000)
    else $error("status pin set without a raw flag");
  a_hold_free: assert property (!(holdover && freerun))
    else $error("holdover and free-run together");
  a_hold_hist: assert property (
    $rose(holdover) |-> $past(history_valid))
    else $error("holdover entered without valid history");
  a_xo_clear: assert property (
    $fell(crystal_loss_flag) |-> $past(xo_in))
    else $error("crystal loss cleared out of range");
  a_xo_set: assert property (
    (clk_en && !xo_in) |-> ##[1:2] crystal_loss_flag)
    else $error("crystal loss not raised out of range");
  a_valid_xo: assert property (ref_valid_out |-> crystal_valid)
    else $error("reference valid without crystal valid");
  a_qual_drop: assert property ((qualified & any_flag) == 4'h0)
    else $error("input qualified while flagged");
  a_qual_quiet: assert property (
    (qualified & ~$past(qualified) & $past(any_flag)) == 4'h0)
    else $error("input qualified right after a flag");
  // main scenarios reached
  cover property ($rose(holdover));
  cover property ($fell(freerun));
  cover property ($rose(crystal_valid) && crystal_loss_flag);
endmodule // drs_ref_select_chk

bind drs_ref_select drs_ref_select_chk i_drs_ref_select_chk
(
  .clk(clk), .nrst(nrst), .clk_en(clk_en),
  .mon_flag_raw(mon_flag_raw), .xo_freq_khz(xo_freq_khz),
  .history_valid(history_valid), .ref_valid_out(ref_valid_out),
  .holdover(holdover), .freerun(freerun), .status_pins(status_pins),
  .qualified(qualified), .crystal_loss_flag(crystal_loss_flag),
  .crystal_valid(crystal_valid)
);

// file: sim/drs_src_model.sv
/*
 model of the four reference sources and the crystal measurement.
 assumes the bench commands faults and the crystal frequency.
*/
`timescale 1ns/1ps
module drs_src_model
(
  // clock
  input wire clk,
  // commands from the bench
  input wire [3:0] fault,
  input wire [19:0] xo_set,
  // towards the selector
  output reg [15:0] mon_flag_raw,
  output reg [19:0] xo_freq_khz
);
  integer i;
  // quiet sources at time zero
  initial
  begin
    mon_flag_raw = 16'h0000;
    xo_freq_khz = 20'h0_0000;
  end
  // a faulted source trips every monitor of its input
  always @(posedge clk)
  begin
    for (i = 0; i < 4; i = i + 1)
      mon_flag_raw[4*i +: 4] <= fault[i] ? 4'hf : 4'h0;
    xo_freq_khz <= xo_set;
  end
endmodule // drs_src_model

// file: sim/drs_ref_select_tb.sv
/*
 self-checking bench for the reference selector.
 assumes the source model for flags and crystal frequency.
*/
`timescale 1ns/1ps
`include "drs_regs.vh"
module drs_ref_select_tb;
  reg clk, nrst, avs_read, avs_write, history_valid, loop_locked;
  reg [7:0] avs_address;
  reg [31:0] avs_writedata;
  reg [1:0] sel_pins;
  reg [3:0] fault;
  reg [19:0] xo_set;
  reg [63:0] note;
  reg [63:0] expq [$];
  integer errors, cmp_count;
  reg clk_en, slew_seen;
  reg [3:0] ref_is_pps;
  integer n_sw, n_step, n_slew, ks, kp;
  wire [1:0] active_ref;
  wire ref_valid_out, holdover, freerun, switch_pulse;
  wire absorb_offset, slew_active, phase_step_pass;
  wire [31:0] avs_readdata;
  wire avs_waitrequest, crystal_loss_flag, crystal_valid;
  wire [15:0] mon_flag_raw, status_pins;
  wire [19:0] xo_freq_khz;
  wire [3:0] qualified;
  drs_ref_select i_drs_ref_select
  (
    .clk(clk), .nrst(nrst), .clk_en(clk_en), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(4'hf),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .mon_flag_raw(mon_flag_raw), .xo_freq_khz(xo_freq_khz),
    .sel_pins(sel_pins), .history_valid(history_valid),
    .loop_locked(loop_locked), .ref_is_pps(ref_is_pps),
    .active_ref(active_ref), .ref_valid_out(ref_valid_out),
    .holdover(holdover), .freerun(freerun), .switch_pulse(switch_pulse),
    .absorb_offset(absorb_offset), .slew_active(slew_active),
    .phase_step_pass(phase_step_pass),
    .status_pins(status_pins), .qualified(qualified),
    .crystal_loss_flag(crystal_loss_flag), .crystal_valid(crystal_valid)
  );
  drs_src_model i_drs_src_model
  (
    .clk(clk), .fault(fault), .xo_set(xo_set),
    .mon_flag_raw(mon_flag_raw), .xo_freq_khz(xo_freq_khz)
  );
  // clock
  always #10 clk = ~clk;
  // counts of pulses and rises on the hitless outputs
  always @(posedge clk)
  begin
    if (switch_pulse === 1'b1)
      n_sw = n_sw + 1;
    if (phase_step_pass === 1'b1)
      n_step = n_step + 1;
    if (slew_active === 1'b1 && !slew_seen)
      n_slew = n_slew + 1;
    slew_seen = (slew_active === 1'b1);
  end
  task chk(input string name, input [31:0] seen, input [31:0] exp);
  begin
    cmp_count = cmp_count + 1;
    if (seen !== exp)
    begin
      errors = errors + 1;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  end
  endtask
  // read data checked against the oldest note
  always @(posedge clk)
    if (avs_read === 1'b1 && avs_waitrequest === 1'b0)
    begin
      note = expq.pop_front();
      chk("readdata", avs_readdata & note[63:32], note[31:0]);
    end
  // one bus cycle, held until waitrequest is sampled low
  task bus(input wr, input [7:0] a, input [31:0] d, input [31:0] m);
    integer n;
  begin
    @(posedge clk);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= wr;
    avs_read <= !wr;
    if (!wr)
      expq.push_back({m, d & m});
    n = 0;
    @(posedge clk);
    while (avs_waitrequest !== 1'b0 && n < 50)
    begin
      n = n + 1;
      @(posedge clk);
    end
    if (n == 50)
      errors = errors + 1;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  end
  endtask
  task wr(input [7:0] a, input [31:0] d);
    bus(1'b1, a, d, 32'h0000_0000);
  endtask
  task rd(input [7:0] a, input [31:0] m, input [31:0] e);
    bus(1'b0, a, e, m);
  endtask
  // loop state after settling: crystal ok, holdover, free-run
  task st(input h, input f);
  begin
    repeat (12) @(posedge clk);
    rd(`DRS_OFS_STAT, 32'h0000_00b0, {26'h0, f, h, 4'h0});
  end
  endtask
  task sel(input [1:0] r, input h, input f);
  begin
    st(h, f);
    rd(`DRS_OFS_MON, 32'h0000_0030, {26'h0, r, 4'h0});
  end
  endtask
  task final_report;
  begin
    $display("Comparisons %0d errors %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  end
  endtask
  // watchdog
  initial
  begin
    repeat (5000) @(posedge clk);
    errors = errors + 1;
    final_report;
  end
  // main sequence
  initial
  begin
    clk = 1'b0;
    nrst = 1'b0;
    {avs_read, avs_write, history_valid, loop_locked} = 4'h0;
    avs_address = 8'h00;
    avs_writedata = 32'h0000_0000;
    sel_pins = 2'h0;
    fault = 4'h0;
    xo_set = `DRS_XO_MIN_KHZ;
    errors = 0;
    cmp_count = 0;
    clk_en = 1'b1;
    ref_is_pps = 4'h0;
    slew_seen = 1'b0;
    n_sw = 0;
    n_step = 0;
    n_slew = 0;
    void'($urandom(32'h6bb4));
    repeat (3) @(posedge clk);
    nrst <= 1'b1;
    rd(`DRS_OFS_STAT, 32'h0000_003f, 32'h0000_0020);
    rd(`DRS_OFS_CTRL, 32'hffff_ffff, `DRS_CTRL_RST);
    rd(`DRS_OFS_PRIO, 32'h0000_ffff, `DRS_PRIO_RST);
    rd(`DRS_OFS_MONEN, 32'h0000_ffff, `DRS_MONEN_RST);
    rd(`DRS_OFS_VALT, 32'h0000_ffff, {16'h0000, `DRS_VALT_RST});
    rd(`DRS_OFS_SLEW, 32'hffff_ffff, `DRS_SLEW_RST);
    rd(8'h40, 32'hffff_ffff, 32'h0000_0000);
    wr(`DRS_OFS_VALT, 32'h0000_0004);
    wr(`DRS_OFS_MONEN, 32'h0000_ffff);
    wr(`DRS_OFS_PRIO, 32'h0000_2013);
    rd(`DRS_OFS_VALT, 32'h0000_ffff, 32'h0000_0004);
    sel(2'd2, 1'b0, 1'b0);
    fault <= 4'h4;
    sel(2'd1, 1'b0, 1'b0);
    fault <= 4'h0;
    sel(2'd2, 1'b0, 1'b0);
    wr(`DRS_OFS_CTRL, 32'h0000_0001);
    fault <= 4'h4;
    sel(2'd1, 1'b0, 1'b0);
    fault <= 4'h0;
    sel(2'd1, 1'b0, 1'b0);
    wr(`DRS_OFS_CTRL, 32'h0000_0000);
    wr(`DRS_OFS_PRIO, 32'h0000_0000);
    sel(2'd0, 1'b0, 1'b0);
    xo_set <= `DRS_XO_MIN_KHZ + 20'($urandom % 32'h0002_4dd9);
    wr(`DRS_OFS_CTRL, 32'h0000_000e);
    sel(2'd3, 1'b0, 1'b0);
    sel_pins <= 2'd1;
    wr(`DRS_OFS_CTRL, 32'h0000_0012);
    sel(2'd1, 1'b0, 1'b0);
    fault <= 4'h2;
    sel(2'd0, 1'b0, 1'b0);
    history_valid <= 1'b1;
    fault <= 4'hf;
    st(1'b1, 1'b0);
    chk("holdover", holdover, 32'h1);
    fault <= 4'hd;
    sel(2'd1, 1'b0, 1'b0);
    wr(`DRS_OFS_CTRL, 32'h0000_000f);
    fault <= 4'h0;
    sel(2'd3, 1'b0, 1'b0);
    fault <= 4'h8;
    st(1'b1, 1'b0);
    fault <= 4'h0;
    sel(2'd3, 1'b0, 1'b0);
    history_valid <= 1'b0;
    fault <= 4'h8;
    st(1'b0, 1'b1);
    chk("freerun", freerun, 32'h1);
    fault <= 4'h9;
    wr(`DRS_OFS_MONEN, 32'h0000_0fff);
    rd(`DRS_OFS_STAT, 32'h0000_0008, 32'h0000_0000);
    st(1'b0, 1'b0);
    @(negedge clk);
    chk("status_pins", status_pins, 32'h0000_0007);
    rd(`DRS_OFS_STAT, 32'h0000_0009, 32'h0000_0008);
    loop_locked <= 1'b1;
    xo_set <= 20'h2_7101;
    repeat (12) @(posedge clk);
    @(negedge clk);
    chk("crystal_loss_flag", crystal_loss_flag, 32'h1);
    chk("crystal_valid", crystal_valid, 32'h0);
    chk("ref_valid_out", ref_valid_out, 32'h0);
    wr(`DRS_OFS_CTRL, 32'h0000_010f);
    repeat (12) @(posedge clk);
    @(negedge clk);
    chk("crystal_valid", crystal_valid, 32'h1);
    chk("crystal_loss_flag", crystal_loss_flag, 32'h1);
    chk("ref_valid_out", ref_valid_out, 32'h1);
    // 1-pps inputs: switch held while zero-delay sync is on
    @(posedge clk);
    xo_set <= `DRS_XO_MAX_KHZ;
    ref_is_pps <= 4'hf;
    wr(`DRS_OFS_CTRL, 32'h0000_0187);
    sel(2'd3, 1'b0, 1'b0);
    rd(`DRS_OFS_PPS, 32'h0000_0003, 32'h0000_0002);
    kp = n_step;
    ks = n_sw;
    wr(`DRS_OFS_CTRL, 32'h0000_0107);
    sel(2'd1, 1'b0, 1'b0);
    chk("active_ref", active_ref, 32'h1);
    chk("switch_pulse", n_sw - ks, 32'h1);
    chk("phase_step_pass", n_step - kp, 32'h1);
    // cancellation between locked inputs, then slewed removal
    wr(`DRS_OFS_FLOCK, 32'h0000_0006);
    wr(`DRS_OFS_CTRL, 32'h0000_032b);
    repeat (12) @(posedge clk);
    rd(`DRS_OFS_STAT, 32'h0000_fff0, 32'h0000_ff00);
    chk("absorb_offset", absorb_offset, 32'h1);
    chk("phase_step_pass", n_step - kp, 32'h1);
    wr(`DRS_OFS_SLEW, 32'h0000_4000);
    wr(`DRS_OFS_CTRL, 32'h0000_036b);
    repeat (12) @(posedge clk);
    rd(`DRS_OFS_STAT, 32'h0000_fff0, 32'h0000_0000);
    chk("absorb_offset", absorb_offset, 32'h0);
    wr(`DRS_OFS_CTRL, 32'h0000_036f);
    sel(2'd3, 1'b0, 1'b0);
    chk("slew_active", n_slew, 32'h1);
    // clock enable low freezes the gated flags
    @(negedge clk);
    chk("status_pins", status_pins, 32'h0000_0008);
    @(posedge clk);
    clk_en <= 1'b0;
    fault <= 4'h0;
    repeat (12) @(posedge clk);
    @(negedge clk);
    chk("status_pins", status_pins, 32'h0000_0008);
    @(posedge clk);
    clk_en <= 1'b1;
    repeat (4) @(posedge clk);
    @(negedge clk);
    chk("status_pins", status_pins, 32'h0000_0000);
    final_report;
  end
endmodule // drs_ref_select_tb
